// ===== src/pte_exc_unit.sv
// privilege, trace and format error exception unit with ahb-lite registers
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pte_defines.svh"
// How it works
// - user mode privileged instruction raises violation
// - coprocessor privilege check in user mode faults
// - fault before execution; supervisor set, trace cleared
// - vector 8, stack offset, status, instruction address
// - trace bits select none, flow, all, reserved
// - trace decided at start, taken after completion
// - flow mode traces branches, traps, status writers
// - in flow mode, breakpoint traced only if substitute changes flow
// - suspended instruction defers trace until normal completion
// - pending trace goes before pending interrupt
// - forced exception first, trace afterwards
// - illegal instructions never produce a trace
// - trace uses vector 9, stacks next address
// - stop traced in all mode loads status, traces, never stops
// - exception return checks format and frame version
// - bad module call or return is not executed
// - coprocessor rejects state frame, format error follows
// - format error: short frame, vector 14, faulting address
// - after stacking, prefetch from handler then resume
module pte_exc_unit (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // instruction stream from the core
  input wire logic instr_start,
  input wire logic [31:0] instr_pc,
  input wire logic instr_priv,
  input wire logic instr_flow,
  input wire logic instr_sw_mod,
  input wire logic instr_breakpoint_instruction,
  input wire logic breakpoint_instruction_sub_flow,
  input wire logic instr_stop,
  input wire logic [15:0] stop_sw_value,
  input wire logic instr_illegal,
  input wire logic instr_done,
  input wire logic [31:0] next_pc,
  input wire logic instr_fault,
  input wire logic instr_resume,
  input wire logic forced_exc_pending,
  input wire logic irq_pending,
  output logic irq_hold,
  output logic enter_stop,
  // frame checks
  input wire logic rte_check,
  input wire logic rte_fmt_ok,
  input wire logic rte_long_frame,
  input wire logic [7:0] rte_stack_version,
  input wire logic mod_check,
  input wire logic mod_fields_ok,
  input wire logic mmu_rights_bad,
  output logic mod_abort,
  // coprocessor
  input wire logic cop_priv_req,
  input wire logic cop_fmt_reject,
  // exception sequencing
  output logic exc_busy,
  output logic [7:0] exc_vector,
  output logic [9:0] exc_offset,
  output logic [31:0] exc_stack_pc,
  output logic [15:0] exc_stack_sw,
  output logic exc_short_frame,
  output logic exc_stack_req,
  input wire logic stack_ack,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  output logic [15:0] status_word
);

  // trace mode of a status word
  function automatic pte_pkg::pte_trace_e trace_mode(input logic [15:0] sw);
    trace_mode = pte_pkg::pte_trace_e'({sw[`PTE_SW_TH], sw[`PTE_SW_TL]});
  endfunction

  logic [15:0] sw_reg, sw_next;
  logic [7:0] ver_reg, last_reg;
  logic [31:0] vbr_reg, spc_reg, cur_pc_reg, trace_pc_reg;
  logic traced_reg, traced_next, stop_reg, stop_tr_reg, susp_reg, trace_pend_reg;
  logic enter_stop_reg;
  pte_pkg::pte_state_e state_reg, state_next;
  logic [7:0] vec_reg, vec_next;
  logic [31:0] stk_pc_reg, stk_pc_next;
  logic short_reg;
  logic [31:0] hrdata_reg, rd_mux;
  logic [7:0] wr_addr_reg;
  logic wr_pend_reg;

  // ahb decode
  wire ahb_go = hsel & hready & htrans[1];
  wire ahb_wr = wr_pend_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign rd_mux = (haddr[7:0] == `PTE_OFF_SW) ? {16'h0000, sw_reg} :
                  (haddr[7:0] == `PTE_OFF_VER) ? {24'h00_0000, ver_reg} :
                  (haddr[7:0] == `PTE_OFF_VBR) ? vbr_reg :
                  (haddr[7:0] == `PTE_OFF_LAST) ? {24'h00_0000, last_reg} :
                  (haddr[7:0] == `PTE_OFF_SPC) ? spc_reg : 32'h0000_0000;

  // bus cycles: address captured, write data taken in data phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata_reg <= 32'h0000_0000;
      wr_addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= ahb_go & hwrite;
      if (ahb_go) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (ahb_go & ~hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // exception requests
  wire idle = (state_reg == pte_pkg::PTE_IDLE);
  wire user = ~sw_reg[`PTE_SW_S];
  wire priv_hit = (instr_start & instr_priv & user) | (cop_priv_req & user);
  wire ver_bad = rte_long_frame & (rte_stack_version != ver_reg);
  wire rte_bad = rte_check & (~rte_fmt_ok | ver_bad);
  wire mod_bad = mod_check & ~mod_fields_ok;
  wire fmt_hit = rte_bad | mod_bad | cop_fmt_reject;
  wire trace_go = trace_pend_reg & ~forced_exc_pending;
  wire take = idle & (fmt_hit | priv_hit | trace_go);
  assign mod_abort = mod_check & (~mod_fields_ok | mmu_rights_bad);
  assign irq_hold = trace_pend_reg;

  // trace qualification at instruction start
  wire pte_pkg::pte_trace_e mode = trace_mode(sw_reg);
  wire flow_hit = instr_flow | instr_sw_mod | (instr_breakpoint_instruction & breakpoint_instruction_sub_flow);
  wire tr_sel = (mode == pte_pkg::PTE_TR_ALL) |
                ((mode == pte_pkg::PTE_TR_FLOW) & flow_hit);
  assign traced_next = instr_start ? (tr_sel & ~instr_illegal & ~priv_hit)
                                   : traced_reg;
  wire done_ok = instr_done & ~susp_reg;

  // trace bookkeeping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      traced_reg <= 1'b0;
      stop_reg <= 1'b0;
      stop_tr_reg <= 1'b0;
      susp_reg <= 1'b0;
      trace_pend_reg <= 1'b0;
      trace_pc_reg <= 32'h0000_0000;
      cur_pc_reg <= 32'h0000_0000;
      enter_stop_reg <= 1'b0;
    end else begin
      traced_reg <= done_ok ? 1'b0 : traced_next;
      if (instr_start) begin
        cur_pc_reg <= instr_pc;
        stop_reg <= instr_stop;
        stop_tr_reg <= instr_stop & (mode == pte_pkg::PTE_TR_ALL);
      end
      if (instr_fault) begin
        susp_reg <= 1'b1;
      end else if (instr_resume) begin
        susp_reg <= 1'b0;
      end
      enter_stop_reg <= done_ok & stop_reg & ~stop_tr_reg;
      if (done_ok & traced_reg) begin
        trace_pend_reg <= 1'b1;
        trace_pc_reg <= next_pc;
      end else if (take & ~fmt_hit & ~priv_hit) begin
        trace_pend_reg <= 1'b0;
      end
    end
  end
  assign enter_stop = enter_stop_reg;

  // exception selection, format first then privilege then trace
  assign vec_next = fmt_hit ? `PTE_VEC_FMT : priv_hit ? `PTE_VEC_PRIV : `PTE_VEC_TRACE;
  assign stk_pc_next = fmt_hit ? cur_pc_reg :
                       priv_hit ? (instr_start ? instr_pc : cur_pc_reg) :
                       trace_pc_reg;

  // status word update
  always_comb begin
    sw_next = sw_reg;
    if (ahb_wr & (wr_addr_reg == `PTE_OFF_SW)) begin
      sw_next = hwdata[15:0];
    end
    if (done_ok & stop_reg) begin
      sw_next = stop_sw_value;
    end
    if (take) begin
      sw_next[`PTE_SW_S] = 1'b1;
      sw_next[`PTE_SW_TH] = 1'b0;
      sw_next[`PTE_SW_TL] = 1'b0;
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pte_pkg::PTE_IDLE: begin
        if (take) begin
          state_next = pte_pkg::PTE_STACK;
        end
      end
      pte_pkg::PTE_STACK: begin
        if (stack_ack) begin
          state_next = pte_pkg::PTE_FETCH;
        end
      end
      pte_pkg::PTE_FETCH: begin
        if (fetch_ack) begin
          state_next = pte_pkg::PTE_IDLE;
        end
      end
    endcase
  end

  // registers and frame contents
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_reg <= `PTE_SW_RST;
      ver_reg <= `PTE_VER_RST;
      vbr_reg <= `PTE_VBR_RST;
      last_reg <= 8'h00;
      spc_reg <= 32'h0000_0000;
      state_reg <= pte_pkg::PTE_IDLE;
      vec_reg <= 8'h00;
      stk_pc_reg <= 32'h0000_0000;
      exc_stack_sw <= 16'h0000;
      short_reg <= 1'b0;
    end else begin
      sw_reg <= sw_next;
      state_reg <= state_next;
      if (ahb_wr & (wr_addr_reg == `PTE_OFF_VER)) begin
        ver_reg <= hwdata[7:0];
      end
      if (ahb_wr & (wr_addr_reg == `PTE_OFF_VBR)) begin
        vbr_reg <= hwdata;
      end
      if (take) begin
        vec_reg <= vec_next;
        last_reg <= vec_next;
        stk_pc_reg <= stk_pc_next;
        spc_reg <= stk_pc_next;
        exc_stack_sw <= sw_reg;
        short_reg <= fmt_hit;
      end
    end
  end

  // frame and handler fetch outputs
  assign exc_busy = ~idle;
  assign exc_vector = vec_reg;
  assign exc_offset = {vec_reg, 2'b00};
  assign exc_stack_pc = stk_pc_reg;
  assign exc_short_frame = short_reg;
  assign exc_stack_req = (state_reg == pte_pkg::PTE_STACK);
  assign fetch_req = (state_reg == pte_pkg::PTE_FETCH);
  assign fetch_addr = vbr_reg + {22'h00_0000, exc_offset};
  assign status_word = sw_reg;

  // checks
  property p_priv_user;
    @(posedge clk) disable iff (sys_rst)
      instr_start & instr_priv & user & idle & ~fmt_hit |=>
        exc_stack_req && exc_vector == 8'h08 && exc_stack_pc == $past(instr_pc);
  endproperty
  a_priv_user: assert property (p_priv_user) else $error("no privilege fault");

  property p_cop_priv;
    @(posedge clk) disable iff (sys_rst)
      cop_priv_req & user & idle & ~fmt_hit |=> exc_vector == 8'h08;
  endproperty
  a_cop_priv: assert property (p_cop_priv) else $error("coprocessor check lost");

  property p_enter_sup;
    @(posedge clk) disable iff (sys_rst)
      $rose(exc_busy) |-> sw_reg[13] && sw_reg[15:14] == 2'b00;
  endproperty
  a_enter_sup: assert property (p_enter_sup) else $error("status not updated");

  property p_all_trace;
    @(posedge clk) disable iff (sys_rst)
      instr_start & (mode == pte_pkg::PTE_TR_ALL) & ~instr_illegal & ~priv_hit |=> traced_reg;
  endproperty
  a_all_trace: assert property (p_all_trace) else $error("trace not armed");

  property p_plain_flow;
    @(posedge clk) disable iff (sys_rst)
      instr_start & (mode == pte_pkg::PTE_TR_FLOW) & ~instr_flow & ~instr_sw_mod & ~instr_breakpoint_instruction
        |=> !traced_reg;
  endproperty
  a_plain_flow: assert property (p_plain_flow) else $error("plain step traced");

  property p_illegal;
    @(posedge clk) disable iff (sys_rst) instr_start & instr_illegal |=> !traced_reg;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal traced");

  property p_susp;
    @(posedge clk) disable iff (sys_rst)
      susp_reg & instr_done & ~trace_pend_reg |=> !trace_pend_reg;
  endproperty
  a_susp: assert property (p_susp) else $error("trace while suspended");

  property p_irq;
    @(posedge clk) disable iff (sys_rst) trace_pend_reg |-> irq_hold;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not held");

  property p_forced;
    @(posedge clk) disable iff (sys_rst)
      forced_exc_pending & idle & ~fmt_hit & ~priv_hit |=> !exc_busy;
  endproperty
  a_forced: assert property (p_forced) else $error("trace before forced");

  property p_trace_frame;
    @(posedge clk) disable iff (sys_rst)
      $rose(exc_busy) && exc_vector == 8'h09 |-> exc_stack_pc == trace_pc_reg;
  endproperty
  a_trace_frame: assert property (p_trace_frame) else $error("trace pc wrong");

  property p_stop;
    @(posedge clk) disable iff (sys_rst)
      instr_done & ~susp_reg & stop_reg & stop_tr_reg |=> !enter_stop && trace_pend_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("traced stop stopped");

  property p_fmt;
    @(posedge clk) disable iff (sys_rst)
      rte_check & rte_long_frame & (rte_stack_version != ver_reg) & idle
        |=> exc_vector == 8'h0E && exc_short_frame ##1 exc_busy;
  endproperty
  a_fmt: assert property (p_fmt) else $error("version mismatch missed");

  property p_fetch;
    @(posedge clk) disable iff (sys_rst)
      fetch_req |-> fetch_addr == vbr_reg + {22'h00_0000, exc_vector, 2'b00};
  endproperty
  a_fetch: assert property (p_fetch) else $error("handler address wrong");

  // a rejected state frame from the coprocessor becomes a short format frame
  property p_cop_fmt;
    @(posedge clk) disable iff (sys_rst)
      cop_fmt_reject & idle |=> exc_vector == 8'h0E && exc_short_frame && exc_stack_req;
  endproperty
  a_cop_fmt: assert property (p_cop_fmt) else $error("frame rejection lost");

  // a refused access rights change always stops the call or return
  property p_mod_abort;
    @(posedge clk) disable iff (sys_rst) mod_check & mmu_rights_bad |-> mod_abort;
  endproperty
  a_mod_abort: assert property (p_mod_abort) else $error("module step not refused");

  // an unblocked pending trace is taken with the trace vector next cycle
  property p_trace_vec;
    @(posedge clk) disable iff (sys_rst)
      trace_go & idle & ~fmt_hit & ~priv_hit |=> exc_vector == 8'h09 && exc_stack_req;
  endproperty
  a_trace_vec: assert property (p_trace_vec) else $error("trace not taken");

  c_priv: cover property (@(posedge clk) disable iff (sys_rst) exc_vector == 8'h08 && fetch_ack);
  c_trace: cover property (@(posedge clk) disable iff (sys_rst) exc_vector == 8'h09 && fetch_ack);
  c_fmt: cover property (@(posedge clk) disable iff (sys_rst) exc_vector == 8'h0E && fetch_ack);
  c_defer: cover property (@(posedge clk) disable iff (sys_rst) trace_pend_reg & forced_exc_pending);

endmodule

// ===== src/pte_defines.svh
// register offsets, status word fields, reset values and vector numbers
`ifndef PTE_DEFINES_SVH
`define PTE_DEFINES_SVH
`define PTE_OFF_SW 8'h00
`define PTE_OFF_VER 8'h04
`define PTE_OFF_VBR 8'h08
`define PTE_OFF_LAST 8'h0C
`define PTE_OFF_SPC 8'h10
`define PTE_SW_TH 15
`define PTE_SW_TL 14
`define PTE_SW_S 13
`define PTE_SW_RST 16'h2700
`define PTE_VER_RST 8'h00
`define PTE_VBR_RST 32'h0000_0000
`define PTE_VEC_PRIV 8'h08
`define PTE_VEC_TRACE 8'h09
`define PTE_VEC_FMT 8'h0E
`endif

// ===== src/pte_pkg.sv
// types shared by the exception unit
package pte_pkg;
  typedef enum logic [1:0] {PTE_TR_NONE, PTE_TR_FLOW, PTE_TR_ALL, PTE_TR_RSVD} pte_trace_e;
  typedef enum logic [1:0] {PTE_IDLE, PTE_STACK, PTE_FETCH} pte_state_e;
endpackage

// ===== dv/pte_cop_model.sv
// coprocessor model raising privilege checks and format rejections
`timescale 1ns/1ps
module pte_cop_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // commands from the bench
  input wire logic go_priv,
  input wire logic go_reject,
  input wire logic [1:0] dly,
  // toward the exception unit
  output logic cop_priv_req,
  output logic cop_fmt_reject
);
  logic [2:0] cnt_reg;
  logic kind_reg;
  // wait the chosen delay, then pulse one request for one cycle
  always_ff @(posedge clk) begin
    cop_priv_req <= 1'b0;
    cop_fmt_reject <= 1'b0;
    if (sys_rst) begin
      cnt_reg <= 3'h0;
      kind_reg <= 1'b0;
    end else if (go_priv || go_reject) begin
      cnt_reg <= {1'b0, dly} + 3'h1;
      kind_reg <= go_reject;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1) begin
        cop_priv_req <= !kind_reg;
        cop_fmt_reject <= kind_reg;
      end
    end
  end
endmodule

// ===== dv/pte_exc_unit_bench.sv
// self-checking bench for the exception unit
`timescale 1ns/1ps
`include "pte_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module pte_exc_unit_bench;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, instr_start, instr_priv;
  logic instr_flow, instr_sw_mod, instr_breakpoint_instruction, breakpoint_instruction_sub_flow, instr_stop, instr_illegal;
  logic instr_done, instr_fault, instr_resume, forced_exc_pending, irq_pending, irq_hold;
  logic enter_stop, rte_check, rte_fmt_ok, rte_long_frame, mod_check, mod_fields_ok;
  logic mmu_rights_bad, mod_abort, cop_priv_req, cop_fmt_reject, exc_busy, exc_short_frame;
  logic exc_stack_req, stack_ack, fetch_req, fetch_ack, go_priv, go_reject;
  logic [31:0] haddr, hwdata, hrdata, instr_pc, next_pc, exc_stack_pc, fetch_addr;
  logic [31:0] r, pc, npc, vbr;
  logic [15:0] stop_sw_value, exc_stack_sw, status_word, sw, v;
  logic [7:0] rte_stack_version, exc_vector, ver;
  logic [9:0] exc_offset;
  logic [8:0] f;
  logic [6:0] b;
  logic [2:0] hsize;
  logic [1:0] htrans, m, dly;
  int n_errors, n_checks, seed, stops, i;
  assign hready = hreadyout;
  pte_exc_unit i_pte_exc_unit (.*);
  pte_cop_model i_pte_cop_model (.clk(clk), .sys_rst(sys_rst), .go_priv(go_priv),
    .go_reject(go_reject), .dly(dly), .cop_priv_req(cop_priv_req),
    .cop_fmt_reject(cop_fmt_reject));
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // stop entries seen
  always @(posedge clk) if (enter_stop === 1'b1) stops++;
  // watchdog
  initial begin
    #60000;
    n_errors++;
    conclude();
  end
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one single ahb-lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic setsw(input logic [15:0] s);
    ahb(1'b1, `PTE_OFF_SW, {16'h0000, s}, r);
    sw = s;
  endtask
  // bits: priv, flow, status writer, breakpoint, substitute flow, stop, illegal
  task automatic ins(input logic [6:0] k);
    pc = $random(seed) & 32'hFFFF_FFFE;
    @(posedge clk);
    instr_pc <= pc;
    {instr_priv, instr_flow, instr_sw_mod, instr_breakpoint_instruction, breakpoint_instruction_sub_flow, instr_stop,
     instr_illegal} <= k;
    instr_start <= 1'b1;
    @(posedge clk) instr_start <= 1'b0;
  endtask
  task automatic done();
    npc = $random(seed) & 32'hFFFF_FFFE;
    @(posedge clk);
    next_pc <= npc;
    instr_done <= 1'b1;
    @(posedge clk) instr_done <= 1'b0;
  endtask
  task automatic cop(input logic rej);
    @(posedge clk);
    go_priv <= !rej;
    go_reject <= rej;
    dly <= 2'($random(seed));
    @(posedge clk) {go_priv, go_reject} <= 2'h0;
  endtask
  task automatic none();
    repeat (6) begin
      @(negedge clk);
      `CHK(exc_busy, 1'b0)
    end
  endtask
  // follow one exception through stacking and prefetch
  task automatic exc(input logic [7:0] e, input logic [31:0] p, input logic [15:0] s);
    int n;
    n = 0;
    @(negedge clk);
    while (exc_stack_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(exc_stack_req, 1'b1)
    `CHK(exc_vector, e)
    `CHK(exc_offset, {e, 2'h0})
    `CHK(exc_stack_pc, p)
    `CHK(exc_stack_sw, s)
    `CHK(status_word[15:13], 3'h1)
    `CHK(exc_short_frame, e == `PTE_VEC_FMT)
    @(posedge clk) stack_ack <= 1'b1;
    @(posedge clk) stack_ack <= 1'b0;
    n = 0;
    while (fetch_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(fetch_req, 1'b1)
    `CHK(fetch_addr, vbr + {22'h00_0000, e, 2'h0})
    @(posedge clk) fetch_ack <= 1'b1;
    @(posedge clk) fetch_ack <= 1'b0;
  endtask
  function automatic logic traced(input logic [1:0] md, input logic [6:0] k);
    if (k[0]) return 1'b0;
    if (md == 2'h2) return 1'b1;
    if (md == 2'h1) return k[5] | k[4] | (k[3] & k[2]);
    return 1'b0;
  endfunction
  // main sequence
  initial begin
    seed = 32'h9db8_7dda;
    sys_rst <= 1'b1;
    {hsel, hwrite, haddr, hwdata, htrans, instr_start, instr_pc, instr_priv, instr_flow,
     instr_sw_mod, instr_breakpoint_instruction, breakpoint_instruction_sub_flow, instr_stop, instr_illegal, instr_done,
     next_pc, instr_fault, instr_resume, forced_exc_pending, irq_pending, rte_check,
     rte_fmt_ok, rte_long_frame, rte_stack_version, mod_check, mod_fields_ok,
     mmu_rights_bad, stop_sw_value, stack_ack, fetch_ack, go_priv, go_reject, dly} <= '0;
    hsize <= 3'h2;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    ahb(1'b0, `PTE_OFF_SW, 32'h0000_0000, r);
    `CHK(r, {16'h0000, `PTE_SW_RST})
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF, r);
    ahb(1'b0, 8'h20, 32'h0000_0000, r);
    `CHK(r, 32'h0000_0000)
    vbr = $random(seed) & 32'hFFFF_FFFC;
    ver = 8'($random(seed));
    ahb(1'b1, `PTE_OFF_VBR, vbr, r);
    ahb(1'b1, `PTE_OFF_VER, {24'h00_0000, ver}, r);
    ahb(1'b0, `PTE_OFF_VBR, 32'h0000_0000, r);
    `CHK(r, vbr)
    for (i = 0; i < 2; i++) begin
      setsw(i ? 16'h2000 : 16'h0000);
      ins(7'h40);
      if (i == 0) exc(`PTE_VEC_PRIV, pc, sw); else none();
      setsw(sw);
      ins(7'h00);
      cop(1'b0);
      if (i == 0) exc(`PTE_VEC_PRIV, pc, sw); else none();
    end
    for (i = 0; i < 16; i++) begin
      m = 2'($random(seed));
      setsw({m, 14'h0000});
      b = 7'($random(seed)) & 7'h3D;
      ins(b);
      setsw({~m, 14'h0000});
      if (!b[0]) done();
      if (traced(m, b)) exc(`PTE_VEC_TRACE, npc, sw); else none();
    end
    setsw(16'h8000);
    ins(7'h00);
    @(posedge clk) instr_fault <= 1'b1;
    @(posedge clk) instr_fault <= 1'b0;
    done();
    none();
    @(posedge clk) instr_resume <= 1'b1;
    @(posedge clk) instr_resume <= 1'b0;
    none();
    @(posedge clk) irq_pending <= 1'b1;
    done();
    @(negedge clk) `CHK(irq_hold, 1'b1)
    exc(`PTE_VEC_TRACE, npc, sw);
    @(posedge clk) irq_pending <= 1'b0;
    setsw(16'h8000);
    ins(7'h00);
    @(posedge clk) forced_exc_pending <= 1'b1;
    done();
    none();
    @(posedge clk) forced_exc_pending <= 1'b0;
    exc(`PTE_VEC_TRACE, npc, sw);
    setsw(16'hA000);
    ins(7'h42);
    v = 16'h2000 | (16'($random(seed)) & 16'h071F);
    @(posedge clk) stop_sw_value <= v;
    done();
    exc(`PTE_VEC_TRACE, npc, v);
    setsw(16'h2000);
    ins(7'h42);
    done();
    none();
    `CHK(stops, 1)
    for (i = 0; i < 7; i++) begin
      f = (i == 0) ? 9'h102 : (i == 1) ? 9'h180 : (i == 2) ? 9'h1E0 : (i == 3) ? 9'h1C2 :
          (i == 4) ? 9'h013 : (i == 5) ? 9'h01D : 9'h018;
      setsw(16'h2000);
      ins(7'h40);
      @(posedge clk) begin
        {rte_check, rte_fmt_ok, rte_long_frame} <= f[8:6];
        rte_stack_version <= ver ^ {7'h00, !f[5]};
        {mod_check, mod_fields_ok, mmu_rights_bad} <= f[4:2];
      end
      @(negedge clk) `CHK(mod_abort, f[0])
      @(posedge clk) {rte_check, mod_check} <= 2'h0;
      if (f[1]) exc(`PTE_VEC_FMT, pc, sw); else none();
    end
    ins(7'h00);
    cop(1'b1);
    exc(`PTE_VEC_FMT, pc, sw);
    ahb(1'b0, `PTE_OFF_LAST, 32'h0000_0000, r);
    `CHK(r, {24'h00_0000, `PTE_VEC_FMT})
    ahb(1'b0, `PTE_OFF_SPC, 32'h0000_0000, r);
    `CHK(r, pc)
    ahb(1'b0, `PTE_OFF_VER, 32'h0000_0000, r);
    `CHK(r, {24'h00_0000, ver})
    conclude();
  end
endmodule
